// *** src/memory_space_pkg.sv ***
package memory_space_pkg;

  // Oscillator periods between address latch pulses
  localparam int ALE_PERIOD = 6;
  localparam logic [2:0] ALE_LAST = 3'h5;
  localparam logic [2:0] PHASE_FIRST = 3'h0;

  // Address space limits
  localparam logic [15:0] ROM_LIMIT = 16'h4000;
  localparam logic [7:0] DIRECT_RAM_LIMIT = 8'h80;
  localparam logic [15:0] AUX_LIMIT = 16'h0100;
  localparam int RAM_DEPTH = 256;
  localparam int SFR_ADDR_W = 7;

  // Reset values of the pin drivers
  localparam logic [7:0] PORT_ALL_ONES = 8'hff;
  localparam logic [7:0] PORT_ALL_ZEROS = 8'h00;

  typedef enum logic [1:0]
  {
    ACC_DIRECT = 2'h0,
    ACC_INDIRECT = 2'h1,
    ACC_XREG = 2'h2,
    ACC_XPTR = 2'h3
  } access_e;

  typedef enum logic [3:0]
  {
    ST_IDLE = 4'h1,
    ST_WAIT = 4'h2,
    ST_ADDR = 4'h4,
    ST_STROBE = 4'h8
  } bus_state_e;

  // True when a data access leaves the chip
  function automatic logic goes_external(input access_e kind, input logic [15:0] addr);
    goes_external = (kind == ACC_XPTR) && (addr >= AUX_LIMIT);
  endfunction

  // True when a direct address falls in the special function area
  function automatic logic hits_sfr(input access_e kind, input logic [7:0] addr);
    hits_sfr = (kind == ACC_DIRECT) && (addr >= DIRECT_RAM_LIMIT);
  endfunction

endpackage

// *** src/byte_store.sv ***
`timescale 1ns/1ps
`default_nettype none
module byte_store
#(
  parameter int DEPTH = 256,
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Access
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);
  typedef struct packed
  {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
  } store_s;

  store_s r;
  store_s n;

  always_comb
  begin
    n = r;
    if (we)
    begin
      n.mem[addr] = wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign rdata = r.mem[addr];
endmodule
`default_nettype wire

// *** src/data_memory_space_decoder.sv ***
// Behaviour
// - Main RAM, auxiliary RAM, SFR area kept apart
// - Main RAM 0-127 direct and indirect
// - Main RAM 128-255 indirect only
// - Auxiliary RAM via external moves, any pointer
// - Auxiliary RAM access leaves ports untouched
// - External data above 255 via data pointer
// - Register pointers never reach external data
// - Address latch pulses every six periods
// - External data access skips one latch pulse
// - Select internal or external program fetch
// - Active-low program store strobe on external fetches
// - Port zero multiplexed, driven strongly on bus
// - Port zero open-drain as plain port
// - Port two carries high address byte
// - Port three write and read strobes
`timescale 1ns/1ps
`default_nettype none
module data_memory_space_decoder
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // CPU data access
  input wire logic cpu_req,
  input wire memory_space_pkg::access_e cpu_kind,
  input wire logic cpu_we,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  output logic busy_r,
  output logic rsp_valid_r,
  output logic [7:0] rsp_data_r,
  // CPU program fetch
  input wire logic fetch_req,
  input wire logic [15:0] fetch_pc,
  input wire logic external_access_select,
  output logic fetch_done_r,
  output logic fetch_internal_r,
  output logic [7:0] fetch_data_r,
  // Special function area
  input wire logic [7:0] sfr_rdata,
  output logic sfr_req_r,
  output logic sfr_we_r,
  output logic [6:0] sfr_addr_r,
  output logic [7:0] sfr_wdata_r,
  // Port latches written by software
  input wire logic [7:0] port_zero_latch,
  input wire logic [7:0] port_two_latch,
  // External bus pins
  input wire logic [7:0] port_zero_in,
  output logic [7:0] port_zero_out_r,
  output logic [7:0] port_zero_oe_r,
  output logic [7:0] port_two_out_r,
  output logic ale_r,
  output logic program_store_strobe_n_r,
  output logic read_strobe_n_r,
  output logic write_strobe_n_r
);
  import memory_space_pkg::*;

  typedef struct packed
  {
    bus_state_e st;
    logic [2:0] phase;
    logic is_fetch;
    logic is_write;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic ale;
    logic program_store_strobe_n;
    logic rd_n;
    logic wr_n;
    logic [7:0] p0_out;
    logic [7:0] p0_oe;
    logic [7:0] p2_out;
    logic bus;
    logic busy;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic fetch_done;
    logic fetch_int;
    logic [7:0] fetch_data;
    logic sfr_req;
    logic sfr_we;
    logic [6:0] sfr_addr;
    logic [7:0] sfr_wdata;
  } ctl_s;

  ctl_s r;
  ctl_s n;
  logic main_we;
  logic aux_we;
  logic [7:0] main_rdata;
  logic [7:0] aux_rdata;
  logic strobe;

  // ----------------------------------------
  // Internal storage
  // ----------------------------------------
  byte_store #(.DEPTH(RAM_DEPTH), .WIDTH(8)) main_ram
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .we(main_we),
    .addr(cpu_addr[7:0]),
    .wdata(cpu_wdata),
    .rdata(main_rdata)
  );

  byte_store #(.DEPTH(RAM_DEPTH), .WIDTH(8)) auxiliary_ram
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .we(aux_we),
    .addr(cpu_addr[7:0]),
    .wdata(cpu_wdata),
    .rdata(aux_rdata)
  );

  // ----------------------------------------
  // Decode and bus sequencing
  // ----------------------------------------
  always_comb
  begin
    n = r;
    main_we = 1'b0;
    aux_we = 1'b0;
    strobe = 1'b0;
    n.rsp_valid = 1'b0;
    n.fetch_done = 1'b0;
    n.sfr_req = 1'b0;
    n.phase = (r.phase == ALE_LAST) ? PHASE_FIRST : r.phase + 3'h1;
    case (r.st)
      ST_IDLE:
      begin
        if (cpu_req)
        begin
          if (hits_sfr(cpu_kind, cpu_addr[7:0]))
          begin
            n.sfr_req = 1'b1;
            n.sfr_we = cpu_we;
            n.sfr_addr = cpu_addr[6:0];
            n.sfr_wdata = cpu_wdata;
            n.rsp_valid = 1'b1;
            n.rsp_data = sfr_rdata;
          end
          else if (cpu_kind == ACC_DIRECT || cpu_kind == ACC_INDIRECT)
          begin
            main_we = cpu_we;
            n.rsp_valid = 1'b1;
            n.rsp_data = main_rdata;
          end
          else if (goes_external(cpu_kind, cpu_addr))
          begin
            n.st = ST_WAIT;
            n.is_fetch = 1'b0;
            n.is_write = cpu_we;
            n.addr = cpu_addr;
            n.wdata = cpu_wdata;
          end
          else
          begin
            // Register pointers carry only the low byte
            aux_we = cpu_we;
            n.rsp_valid = 1'b1;
            n.rsp_data = aux_rdata;
          end
        end
        else if (fetch_req)
        begin
          if (external_access_select && fetch_pc < ROM_LIMIT)
          begin
            n.fetch_done = 1'b1;
            n.fetch_int = 1'b1;
          end
          else
          begin
            n.st = ST_WAIT;
            n.is_fetch = 1'b1;
            n.is_write = 1'b0;
            n.addr = fetch_pc;
          end
        end
      end
      ST_WAIT:
      begin
        if (r.phase == ALE_LAST)
        begin
          n.st = ST_ADDR;
        end
      end
      ST_ADDR:
      begin
        if (r.phase == ALE_LAST)
        begin
          n.st = ST_STROBE;
        end
      end
      ST_STROBE:
      begin
        if (r.phase == ALE_LAST)
        begin
          n.st = ST_IDLE;
          if (r.is_fetch)
          begin
            n.fetch_done = 1'b1;
            n.fetch_int = 1'b0;
            n.fetch_data = port_zero_in;
          end
          else
          begin
            n.rsp_valid = 1'b1;
            n.rsp_data = r.is_write ? r.wdata : port_zero_in;
          end
        end
      end
      default:
      begin
        n.st = ST_IDLE;
      end
    endcase
    // Pins follow the next state so they change with it
    n.busy = (n.st != ST_IDLE);
    n.bus = (n.st == ST_ADDR) || (n.st == ST_STROBE);
    strobe = (n.st == ST_STROBE);
    n.ale = (n.phase == PHASE_FIRST) && !(strobe && !n.is_fetch);
    n.program_store_strobe_n = !(strobe && n.is_fetch);
    n.rd_n = !(strobe && !n.is_fetch && !n.is_write);
    n.wr_n = !(strobe && !n.is_fetch && n.is_write);
    if (n.st == ST_ADDR)
    begin
      n.p0_out = n.addr[7:0];
      n.p0_oe = PORT_ALL_ONES;
    end
    else if (strobe && !n.is_fetch && n.is_write)
    begin
      n.p0_out = n.wdata;
      n.p0_oe = PORT_ALL_ONES;
    end
    else if (strobe)
    begin
      n.p0_out = PORT_ALL_ZEROS;
      n.p0_oe = PORT_ALL_ZEROS;
    end
    else
    begin
      // Open drain: only zeros are driven
      n.p0_out = PORT_ALL_ZEROS;
      n.p0_oe = ~port_zero_latch;
    end
    n.p2_out = n.bus ? n.addr[15:8] : port_two_latch;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.st <= ST_IDLE;
      r.program_store_strobe_n <= 1'b1;
      r.rd_n <= 1'b1;
      r.wr_n <= 1'b1;
      r.p2_out <= PORT_ALL_ONES;
    end
    else
    begin
      r <= n;
    end
  end

  assign busy_r = r.busy;
  assign rsp_valid_r = r.rsp_valid;
  assign rsp_data_r = r.rsp_data;
  assign fetch_done_r = r.fetch_done;
  assign fetch_internal_r = r.fetch_int;
  assign fetch_data_r = r.fetch_data;
  assign sfr_req_r = r.sfr_req;
  assign sfr_we_r = r.sfr_we;
  assign sfr_addr_r = r.sfr_addr;
  assign sfr_wdata_r = r.sfr_wdata;
  assign port_zero_out_r = r.p0_out;
  assign port_zero_oe_r = r.p0_oe;
  assign port_two_out_r = r.p2_out;
  assign ale_r = r.ale;
  assign program_store_strobe_n_r = r.program_store_strobe_n;
  assign read_strobe_n_r = r.rd_n;
  assign write_strobe_n_r = r.wr_n;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  logic take;
  assign take = (r.st == ST_IDLE) && cpu_req;

  sequence strobe_low_window;
    !read_strobe_n_r [*6];
  endsequence

  chk_ale_spacing: assert property (ale_r |=> !ale_r [*5])
    else $error("address latch pulses closer than six periods");
  chk_ale_skip: assert property ($fell(read_strobe_n_r) |-> strobe_low_window and (!ale_r [*6]))
    else $error("latch pulse during external data strobe");
  chk_aux_quiet: assert property (take && !goes_external(cpu_kind, cpu_addr)
    |=> read_strobe_n_r && write_strobe_n_r && !r.bus)
    else $error("internal access moved the external bus");
  chk_reg_pointer: assert property (take && cpu_kind == ACC_XREG |=> r.st == ST_IDLE && rsp_valid_r)
    else $error("register pointer started an external cycle");
  chk_rom_fetch: assert property ((r.st == ST_IDLE) && !cpu_req && fetch_req && external_access_select
    && fetch_pc < ROM_LIMIT |=> fetch_done_r && fetch_internal_r && program_store_strobe_n_r)
    else $error("internal fetch not served on chip");
  chk_program_store_strobe_fetch: assert property (!program_store_strobe_n_r |-> r.is_fetch && read_strobe_n_r)
    else $error("program store strobe outside a fetch");
  chk_port_zero_od: assert property (!r.bus |-> port_zero_out_r == PORT_ALL_ZEROS)
    else $error("port zero drove a one as plain port");
  chk_addr_phase: assert property (r.st == ST_ADDR |-> port_zero_oe_r == PORT_ALL_ONES
    && port_zero_out_r == r.addr[7:0] && port_two_out_r == r.addr[15:8])
    else $error("address not on ports during address phase");
  chk_ext_data: assert property (take && goes_external(cpu_kind, cpu_addr) && cpu_we
    |-> ##[8:13] !write_strobe_n_r)
    else $error("external write strobe missing");
  chk_sfr_direct: assert property (take && hits_sfr(cpu_kind, cpu_addr[7:0]) |=> sfr_req_r)
    else $error("direct high address missed the SFR area");
  chk_upper_ram: assert property (take && cpu_kind == ACC_INDIRECT |=> !sfr_req_r && rsp_valid_r)
    else $error("indirect access left main RAM");
endmodule
`default_nettype wire

// *** dv/ext_memory_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ext_memory_model
(
  // Bus pins
  input wire logic core_clk,
  input wire logic [7:0] p0_out,
  input wire logic [7:0] p0_oe,
  input wire logic [7:0] p2_out,
  input wire logic ale,
  input wire logic program_store_strobe_n,
  input wire logic rd_n,
  input wire logic wr_n,
  // Cycles before read data is valid
  input wire logic [2:0] dly,
  output logic [7:0] p0_in,
  output logic [15:0] lat
);
  logic [7:0] mem [0:65535];
  logic [7:0] last;
  logic [2:0] cnt;
  logic drv;
  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'(i) ^ 8'(i >> 8);
    lat = 16'h0000;
    last = 8'h00;
    cnt = 3'h0;
  end
  // Address latch captures the pins on the falling edge of its strobe
  always @(negedge ale)
    lat = {p2_out, p0_out};
  always @(posedge core_clk)
  begin
    last <= p0_in;
    cnt <= (!rd_n || !program_store_strobe_n) ? cnt + 3'h1 : 3'h0;
    if (!wr_n && &p0_oe)
      mem[lat] <= p0_out;
  end
  assign drv = (!rd_n || !program_store_strobe_n) && cnt >= dly;
  // Released pad shows the inverse of its last level
  always @*
    for (int i = 0; i < 8; i++)
      p0_in[i] = p0_oe[i] ? p0_out[i] : (drv ? mem[lat][i] : ~last[i]);
endmodule
`default_nettype wire

// *** dv/data_memory_space_decoder_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module data_memory_space_decoder_tb;
  import memory_space_pkg::*;
  logic core_clk, rst_n, req, we, freq, ea, busy, rv, fd, fi, sreq, swe;
  logic ale, ps_n, rd_n, wr_n, bsy;
  access_e kind;
  logic [15:0] addr, pc, lat;
  logic [7:0] wd, srd, p0l, p2l, p0i, rdat, fdat, sw, p0o, p0e, p2o, dat;
  logic [6:0] sad;
  logic [2:0] dly;
  int bad_count, n_compared, rdc, wrc, psc, sfc, gap, mx;
  // ----
  // Design and far side
  // ----
  data_memory_space_decoder i_data_memory_space_decoder (.core_clk(core_clk), .rst_n(rst_n),
    .cpu_req(req), .cpu_kind(kind), .cpu_we(we), .cpu_addr(addr), .cpu_wdata(wd), .busy_r(busy),
    .rsp_valid_r(rv), .rsp_data_r(rdat), .fetch_req(freq), .fetch_pc(pc), .external_access_select(ea),
    .fetch_done_r(fd), .fetch_internal_r(fi), .fetch_data_r(fdat), .sfr_rdata(srd), .sfr_req_r(sreq),
    .sfr_we_r(swe), .sfr_addr_r(sad), .sfr_wdata_r(sw), .port_zero_latch(p0l), .port_two_latch(p2l),
    .port_zero_in(p0i), .port_zero_out_r(p0o), .port_zero_oe_r(p0e), .port_two_out_r(p2o),
    .ale_r(ale), .program_store_strobe_n_r(ps_n), .read_strobe_n_r(rd_n), .write_strobe_n_r(wr_n));
  ext_memory_model i_ext_memory_model (.core_clk(core_clk), .p0_out(p0o), .p0_oe(p0e), .p2_out(p2o),
    .ale(ale), .program_store_strobe_n(ps_n), .rd_n(rd_n), .wr_n(wr_n), .dly(dly), .p0_in(p0i), .lat(lat));
  always @(posedge core_clk)
  begin
    rdc += int'(rd_n === 1'b0);
    wrc += int'(wr_n === 1'b0);
    psc += int'(ps_n === 1'b0);
    sfc += int'(sreq === 1'b1);
    gap++;
    if (ale === 1'b1)
    begin
      mx = (gap - 1 > mx) ? gap - 1 : mx;
      gap = 1;
    end
  end
  // ----
  // Shared tasks
  // ----
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (bad_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic await(input logic of_fetch);
    int n;
    n = 0;
    while ((of_fetch ? fd : rv) !== 1'b1)
    begin
      @(negedge core_clk);
      n++;
      if (n > 40)
      begin
        bad_count++;
        results();
      end
    end
  endtask
  task automatic acc(input access_e k, input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk);
    kind = k;
    {we, addr, wd, req} = {w, a, d, 1'b1};
    {rdc, wrc, psc, sfc, mx} = '0;
    @(negedge core_clk);
    req = 1'b0;
    bsy = busy;
    await(1'b0);
    dat = rdat;
  endtask
  task automatic fetch(input logic e, input logic [15:0] p);
    @(negedge core_clk);
    {ea, pc, freq} = {e, p, 1'b1};
    {psc, mx} = '0;
    @(negedge core_clk);
    freq = 1'b0;
    await(1'b1);
    dat = fdat;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_idle();
    // Forget the gap that spans reset before measuring latch spacing
    {gap, mx} = '0;
    check({p0e, p0o}, {~p0l, 8'h00});
    check({p2o, 5'h0, ps_n, rd_n, wr_n}, {p2l, 8'h07});
    repeat (24) @(negedge core_clk);
    check(16'(mx), 16'd6);
  endtask
  task automatic t_main();
    acc(ACC_DIRECT, 1'b1, 16'h0010, 8'h11);
    acc(ACC_INDIRECT, 1'b0, 16'h0010, 8'h00);
    check(dat, 8'h11);
    check(16'(bsy), 16'd0);
    acc(ACC_INDIRECT, 1'b1, 16'h0090, 8'ha5);
    acc(ACC_DIRECT, 1'b1, 16'h0090, 8'h77);
    @(negedge core_clk);
    check(16'(sfc), 16'd1);
    check({swe, sad, sw}, {1'b1, 7'h10, 8'h77});
    acc(ACC_DIRECT, 1'b0, 16'h0090, 8'h00);
    check(dat, srd);
    acc(ACC_INDIRECT, 1'b0, 16'h0090, 8'h00);
    check(dat, 8'ha5);
  endtask
  task automatic t_aux();
    acc(ACC_XREG, 1'b1, 16'hff20, 8'h66);
    check(16'(bsy), 16'd0);
    // Let at least one latch pulse pass so its spacing is seen
    repeat (7) @(negedge core_clk);
    check(16'(rdc + wrc + mx), 16'd6);
    check(p2o, p2l);
    acc(ACC_XPTR, 1'b0, 16'h0020, 8'h00);
    check(dat, 8'h66);
    acc(ACC_INDIRECT, 1'b0, 16'h0020, 8'h00);
    check(dat, 8'h00);
    acc(ACC_XREG, 1'b0, 16'h1234, 8'h00);
    check({dat, 8'(rdc)}, 16'h0000);
  endtask
  task automatic t_ext();
    acc(ACC_XPTR, 1'b1, 16'h1234, 8'h5a);
    check(16'(bsy), 16'd1);
    check(16'(wrc), 16'd6);
    check(lat, 16'h1234);
    // The resumed latch pulse is counted on the next rising edge
    @(negedge core_clk);
    check(16'(mx), 16'd12);
    dly = 3'h4;
    acc(ACC_XPTR, 1'b0, 16'h1234, 8'h00);
    check({dat, 8'(rdc)}, 16'h5a06);
    dly = 3'h0;
    acc(ACC_XPTR, 1'b0, 16'hab00, 8'h00);
    check({dat, lat[15:8]}, 16'habab);
  endtask
  task automatic t_fetch();
    fetch(1'b1, 16'h3fff);
    check({7'h0, fi, 8'(psc)}, 16'h0100);
    fetch(1'b1, ROM_LIMIT);
    check({fi, dat[6:0], 8'(psc)}, 16'h4006);
    check(16'(mx), 16'd6);
    fetch(1'b0, 16'h0100);
    check({7'h0, fi, dat}, 16'h0001);
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial
  begin
    {rst_n, req, we, freq, addr, pc, wd, dly} = '0;
    kind = ACC_DIRECT;
    {bad_count, n_compared, rdc, wrc, psc, sfc, gap, mx} = '0;
    ea = 1'b1;
    srd = 8'h3c;
    p0l = 8'h0f;
    p2l = 8'hc3;
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    t_idle();
    t_main();
    t_aux();
    t_ext();
    t_fetch();
    results();
  end
endmodule
`default_nettype wire
